/* design/frc_pkg.sv */
// Shared types and constants for the release controller
package frc_pkg;
  typedef enum logic [1:0] {
    CL_SHORT = 2'h0,
    CL_R47K = 2'h1,
    CL_R23K5 = 2'h2,
    CL_OPEN = 2'h3
  } frc_class_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_COUNT = 3'h1,
    ST_FIRED = 3'h3,
    ST_DONE = 3'h2,
    ST_HOLD = 3'h4
  } frc_state_t;

  typedef struct packed {
    frc_class_t loop1;
    frc_class_t loop2;
    frc_class_t remote;
  } frc_loops_t;

  typedef struct packed {
    logic gen1;
    logic gen2;
    logic out1;
    logic out2;
    logic sounder;
    logic fault_led;
    logic alarm_led;
    logic act_led;
  } frc_drive_t;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [3:0] RELEASE_S = 4'hf;
  localparam logic [3:0] STAG_SHORT_S = 4'h5;
  localparam logic [3:0] STAG_LONG_S = 4'ha;
  localparam logic [3:0] HOLD_S = 4'h5;
  localparam int BREAK_S = 1;

  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_FAULT = 4'h2;
  localparam logic [7:0] CFG_RESET = 8'h00;

  localparam int SW_LOOP1 = 0;
  localparam int SW_BOTHREQ = 1;
  localparam int SW_LOOP2 = 2;
  localparam int SW_MANUAL = 4;
  localparam int SW_RELEASE = 5;
  localparam int SW_SECOND = 6;
  localparam int SW_LONG = 7;

  localparam int F_LOOP1 = 0;
  localparam int F_LOOP2 = 1;
  localparam int F_REMOTE = 2;
  localparam int F_BRK1 = 3;
  localparam int F_BRK2 = 4;
  localparam int F_DISCH = 5;
  localparam int F_LED = 6;
endpackage

/* design/frc_release_ctrl.sv */
// Release decision, delays, fault gathering and register port
module frc_release_ctrl
  import frc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire frc_loops_t loops,
  input wire logic ignition,
  input wire logic btn_a,
  input wire logic btn_b,
  input wire logic [1:0] gen_open,
  input wire logic discharge_fail,
  input wire logic [3:0] led_main_fail,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output frc_drive_t drive,
  output logic [3:0] spare_sel
);
  localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);
  localparam logic [25:0] TICK_HALF = 26'(TICK_CYCLES / 2);
  localparam logic [25:0] BRK_LAST = 26'(BREAK_S * TICK_CYCLES - 1);

  frc_state_t state_reg, state_next;
  logic [7:0] cfg_reg;
  logic [6:0] fault_reg, fault_next;
  logic [25:0] div_reg;
  logic [3:0] sec_reg;
  logic fire2_reg;
  logic [7:0] rdata_reg;
  frc_drive_t drive_reg, drive_next;
  logic [3:0] spare_reg;
  logic [25:0] brk_cnt [2];
  logic [1:0] brk_flag;

  // Loop classification
  wire l1_alarm = (loops.loop1 == CL_SHORT);
  wire l1_fault = (loops.loop1 == CL_OPEN);
  wire l2_alarm = (loops.loop2 == CL_R47K);
  wire l2_fault = (loops.loop2 == CL_OPEN) || (loops.loop2 == CL_SHORT);
  wire rem_alarm = (loops.remote == CL_R23K5);
  wire rem_fault = (loops.remote == CL_OPEN) || (loops.remote == CL_SHORT);

  // Mode and configuration decode
  wire manual_mode = cfg_reg[SW_MANUAL] & ignition;
  wire release_en = cfg_reg[SW_RELEASE];
  wire both_req = cfg_reg[SW_BOTHREQ];
  wire l1_sel = cfg_reg[SW_LOOP1] & l1_alarm;
  wire l2_sel = cfg_reg[SW_LOOP2] & l2_alarm;
  wire any_alarm = l1_alarm | l2_alarm;
  wire loop_trig = both_req ? (l1_alarm & l2_alarm) : (l1_sel | l2_sel);
  wire trigger = release_en & ~manual_mode & loop_trig;
  wire shutdown = release_en & both_req & (l1_alarm ^ l2_alarm);
  wire buttons = btn_a & btn_b;
  wire second_en = cfg_reg[SW_SECOND];
  wire [3:0] stagger = cfg_reg[SW_LONG] ? STAG_LONG_S : STAG_SHORT_S;

  // One-second tick, restarted on each state change
  wire state_chg = (state_next != state_reg);
  wire tick = (div_reg == TICK_LAST);
  wire half_on = (div_reg < TICK_HALF);
  wire release_done = tick && (sec_reg == RELEASE_S - 4'h1);
  wire hold_done = tick && (sec_reg == HOLD_S - 4'h1);
  wire stag_done = tick && (sec_reg == stagger - 4'h1);
  wire fired = (state_reg == ST_FIRED) || (state_reg == ST_DONE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rem_alarm) begin
          state_next = ST_FIRED;
        end else if (buttons) begin
          state_next = ST_HOLD;
        end else if (trigger) begin
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (release_done) begin
          state_next = ST_FIRED;
        end
      end
      ST_HOLD: begin
        if (!buttons) begin
          state_next = ST_IDLE;
        end else if (hold_done) begin
          state_next = ST_FIRED;
        end
      end
      ST_FIRED: begin
        if (!second_en || stag_done) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Generator loop break persistence
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_brk
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          brk_cnt[g] <= 26'h0;
          brk_flag[g] <= 1'b0;
        end else if (!gen_open[g]) begin
          brk_cnt[g] <= 26'h0;
          brk_flag[g] <= 1'b0;
        end else if (brk_cnt[g] == BRK_LAST) begin
          brk_flag[g] <= 1'b1;
        end else begin
          brk_cnt[g] <= brk_cnt[g] + 26'h1;
        end
      end
    end
  endgenerate

  // Sticky faults, set wins over write-one clear
  wire fault_wr = wr && (addr == ADDR_FAULT);
  wire [6:0] fault_clr = fault_wr ? wdata[6:0] : 7'h00;
  wire [6:0] fault_set = {|led_main_fail, discharge_fail & fired, brk_flag[1], brk_flag[0],
                          rem_fault, l2_fault, l1_fault};
  wire fault_any = |fault_next;

  always_comb begin
    fault_next = (fault_reg & ~fault_clr) | fault_set;
    drive_next = '0;
    drive_next.gen1 = fired;
    drive_next.gen2 = fire2_reg;
    drive_next.out1 = fault_any;
    drive_next.out2 = shutdown;
    drive_next.fault_led = fault_any;
    drive_next.alarm_led = any_alarm | rem_alarm;
    drive_next.act_led = fired;
    drive_next.sounder = fault_any | fired | (state_reg == ST_COUNT) |
                         ((state_reg == ST_HOLD) & half_on);
  end

  // Register read mux
  wire [7:0] stat_word = {1'b0, manual_mode, drive_reg.out2, drive_reg.gen2, drive_reg.gen1, state_reg};
  wire [7:0] rd_mux = (addr == ADDR_CFG) ? cfg_reg :
                      (addr == ADDR_STAT) ? stat_word :
                      (addr == ADDR_FAULT) ? {1'b0, fault_reg} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      div_reg <= 26'h0;
      sec_reg <= 4'h0;
      fire2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= (state_chg || tick) ? 26'h0 : div_reg + 26'h1;
      sec_reg <= state_chg ? 4'h0 : sec_reg + {3'h0, tick};
      fire2_reg <= fire2_reg | ((state_reg == ST_FIRED) & second_en & stag_done);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
      fault_reg <= 7'h00;
      rdata_reg <= 8'h00;
      drive_reg <= '0;
      spare_reg <= 4'h0;
    end else begin
      if (wr && (addr == ADDR_CFG)) begin
        cfg_reg <= wdata;
      end
      fault_reg <= fault_next;
      rdata_reg <= rd ? rd_mux : 8'h00;
      drive_reg <= drive_next;
      spare_reg <= led_main_fail;
    end
  end

  assign rdata = rdata_reg;
  assign drive = drive_reg;
  assign spare_sel = spare_reg;

  // Checks
  property p_release_delay;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_COUNT) ##1 (state_reg == ST_FIRED) |-> $past(sec_reg) == 4'he && $past(tick);
  endproperty
  a_release_delay: assert property (p_release_delay) else $error("primary fired off 15 s");

  property p_stagger;
    @(posedge clk) disable iff (rst)
    $rose(fire2_reg) |-> $past(state_reg) == ST_FIRED && $past(sec_reg) == $past(stagger) - 4'h1;
  endproperty
  a_stagger: assert property (p_stagger) else $error("secondary stagger wrong");

  property p_manual_no_count;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE && manual_mode && !buttons && !rem_alarm) |=> state_reg == ST_IDLE;
  endproperty
  a_manual_no_count: assert property (p_manual_no_count) else $error("manual mode counted");

  property p_auto_start;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE && trigger && !buttons && !rem_alarm) |=> state_reg == ST_COUNT;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto countdown not started");

  property p_shutdown;
    @(posedge clk) disable iff (rst)
    (release_en && both_req && l1_alarm && !l2_alarm && state_reg == ST_IDLE && !buttons && !rem_alarm)
      |=> drive.out2 && state_reg == ST_IDLE;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown missing or fired");

  property p_warning_only;
    @(posedge clk) disable iff (rst)
    (!release_en && state_reg == ST_IDLE && !buttons && !rem_alarm) |=> !fired;
  endproperty
  a_warning_only: assert property (p_warning_only) else $error("warning config fired");

  property p_fault_out;
    @(posedge clk) disable iff (rst)
    (l1_fault || l2_fault || rem_fault) |=> drive.out1 && drive.fault_led && drive.sounder;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("fault not shown");

  property p_hold_abort;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD && !buttons) |=> state_reg == ST_IDLE ##1 !drive.gen1;
  endproperty
  a_hold_abort: assert property (p_hold_abort) else $error("early release not aborted");

  property p_hold_fire;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD) ##1 (state_reg == ST_FIRED) |-> $past(sec_reg) == 4'h4 ##1 drive.gen1 && drive.sounder;
  endproperty
  a_hold_fire: assert property (p_hold_fire) else $error("hold fire timing wrong");

  property p_count_holds;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_COUNT && !loop_trig && !release_done) |=> state_reg == ST_COUNT;
  endproperty
  a_count_holds: assert property (p_count_holds) else $error("countdown aborted");

  property p_break_persist;
    @(posedge clk) disable iff (rst)
    $rose(brk_flag[0]) |-> $past(brk_cnt[0]) == BRK_LAST && $past(gen_open[0]);
  endproperty
  a_break_persist: assert property (p_break_persist) else $error("break fault too early");

  property p_spare;
    @(posedge clk) disable iff (rst)
    led_main_fail[0] |=> spare_sel[0] && fault_reg[F_LED];
  endproperty
  a_spare: assert property (p_spare) else $error("spare lamp not used");

  // Cycles spent in the present state, for the delay checks
  localparam int REL_CYC = int'(RELEASE_S) * TICK_CYCLES;
  localparam int HOLD_CYC = int'(HOLD_S) * TICK_CYCLES;
  localparam int SHORT_CYC = int'(STAG_SHORT_S) * TICK_CYCLES;
  localparam int LONG_CYC = int'(STAG_LONG_S) * TICK_CYCLES;
  logic [31:0] dwell_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dwell_reg <= 32'h0;
    end else begin
      dwell_reg <= state_chg ? 32'h1 : dwell_reg + 32'h1;
    end
  end

  property p_release_time;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_COUNT && state_next == ST_FIRED) |-> dwell_reg == 32'(REL_CYC);
  endproperty
  a_release_time: assert property (p_release_time) else $error("countdown length wrong");

  property p_stag_time;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_FIRED && second_en && state_next == ST_DONE) |->
      dwell_reg == (cfg_reg[SW_LONG] ? 32'(LONG_CYC) : 32'(SHORT_CYC));
  endproperty
  a_stag_time: assert property (p_stag_time) else $error("stagger length wrong");

  property p_hold_time;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD && state_next == ST_FIRED) |-> dwell_reg == 32'(HOLD_CYC);
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("hold length wrong");

  property p_shutdown_out;
    @(posedge clk) disable iff (rst)
    drive.out2 == $past(shutdown);
  endproperty
  a_shutdown_out: assert property (p_shutdown_out) else $error("shutdown output wrong");

  property p_alarm_lamp;
    @(posedge clk) disable iff (rst)
    (loops.loop1 == CL_SHORT || loops.loop2 == CL_R47K) |=> drive.alarm_led;
  endproperty
  a_alarm_lamp: assert property (p_alarm_lamp) else $error("alarm lamp missing");

  property p_disch_fault;
    @(posedge clk) disable iff (rst)
    (discharge_fail && fired) |=> fault_reg[F_DISCH] && drive.fault_led;
  endproperty
  a_disch_fault: assert property (p_disch_fault) else $error("discharge fault missing");

  property p_brk1_fault;
    @(posedge clk) disable iff (rst)
    brk_flag[0] |=> fault_reg[F_BRK1] && drive.out1;
  endproperty
  a_brk1_fault: assert property (p_brk1_fault) else $error("primary break fault missing");

  property p_brk2_fault;
    @(posedge clk) disable iff (rst)
    brk_flag[1] |=> fault_reg[F_BRK2] && drive.out1;
  endproperty
  a_brk2_fault: assert property (p_brk2_fault) else $error("secondary break fault missing");

  property p_remote_fault;
    @(posedge clk) disable iff (rst)
    (loops.remote == CL_OPEN || loops.remote == CL_SHORT) |=> fault_reg[F_REMOTE];
  endproperty
  a_remote_fault: assert property (p_remote_fault) else $error("remote loop fault missing");

  property p_loop1_fault;
    @(posedge clk) disable iff (rst)
    (loops.loop1 == CL_OPEN) |=> fault_reg[F_LOOP1];
  endproperty
  a_loop1_fault: assert property (p_loop1_fault) else $error("loop 1 fault missing");

  property p_loop2_fault;
    @(posedge clk) disable iff (rst)
    (loops.loop2 == CL_OPEN || loops.loop2 == CL_SHORT) |=> fault_reg[F_LOOP2];
  endproperty
  a_loop2_fault: assert property (p_loop2_fault) else $error("loop 2 fault missing");

  property p_hold_quiet;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD && tick && !fault_any) |=> !drive.sounder;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("hold tone not intermittent");

  property p_hold_beep;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD && div_reg == 26'h0) |=> drive.sounder;
  endproperty
  a_hold_beep: assert property (p_hold_beep) else $error("hold tone missing");

  property p_gen_latch;
    @(posedge clk) disable iff (rst)
    drive.gen1 |=> drive.gen1 && drive.act_led;
  endproperty
  a_gen_latch: assert property (p_gen_latch) else $error("primary output dropped");

  c_auto_fire: cover property (@(posedge clk) disable iff (rst) (state_reg == ST_COUNT) ##1 (state_reg == ST_FIRED));
  c_hold_fire: cover property (@(posedge clk) disable iff (rst) (state_reg == ST_HOLD) ##1 (state_reg == ST_FIRED));
  c_hold_abort: cover property (@(posedge clk) disable iff (rst) (state_reg == ST_HOLD) ##1 (state_reg == ST_IDLE));
  c_secondary: cover property (@(posedge clk) disable iff (rst) $rose(fire2_reg));
endmodule

/* test/frc_field_model.sv */
// Field model: alarm loops and generator firing circuits
module frc_field_model
  import frc_pkg::*;
(
  input wire logic clk,
  input wire frc_drive_t drive,
  input wire logic [1:0] alm,
  input wire logic [2:0] bad,
  input wire logic [1:0] cut,
  input wire logic misfire,
  input wire logic press,
  output frc_loops_t loops,
  output logic [1:0] gen_open,
  output logic discharge_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {loops, gen_open, discharge_fail} = '0;
  always @(posedge clk) begin
    loops.loop1 <= bad[0] ? CL_OPEN : alm[0] ? CL_SHORT : CL_R47K;
    loops.loop2 <= bad[1] ? CL_SHORT : alm[1] ? CL_R47K : CL_R23K5;
    loops.remote <= bad[2] ? CL_OPEN : press ? CL_R23K5 : CL_R47K;
    gen_open <= cut;
    discharge_fail <= misfire & drive.gen1;
  end
endmodule

/* test/tb_frc_release_ctrl.sv */
// Self-checking bench for the release controller
module tb_frc_release_ctrl
  import frc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ignition = 1'b0;
  logic btn_a = 1'b0;
  logic btn_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic misfire = 1'b0;
  logic press = 1'b0;
  logic [1:0] alm = '0;
  logic [5:0] cause = '0;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [3:0] spare_sel;
  logic [1:0] gen_open;
  logic discharge_fail;
  frc_loops_t loops;
  frc_drive_t drive;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  initial forever #10 clk = ~clk;

  frc_field_model fm_u (.clk(clk), .drive(drive), .alm(alm), .bad(cause[2:0]), .cut(cause[4:3]),
    .misfire(misfire), .press(press), .loops(loops), .gen_open(gen_open), .discharge_fail(discharge_fail));
  frc_release_ctrl #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .rst(rst), .loops(loops), .ignition(ignition),
    .btn_a(btn_a), .btn_b(btn_b), .gen_open(gen_open), .discharge_fail(discharge_fail),
    .led_main_fail({3'h0, cause[5]}), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .drive(drive), .spare_sel(spare_sel));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tk(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    {alm, cause, misfire, press, ignition, btn_a, btn_b} <= '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Generator edge expected n cycles on
  task automatic fire_chk(string nm, bit sec, int n);
    tk(n - 1);
    chk(nm, 8'(sec ? drive.gen2 : drive.gen1), 8'h00);
    tk(1);
    chk(nm, 8'(sec ? drive.gen2 : drive.gen1), 8'h01);
  endtask

  task automatic t_warn();
    do_reset();
    rd_reg(ADDR_CFG);
    chk("cfg", v, 8'h00);
    wr_reg(ADDR_CFG, 8'h05);
    @(posedge clk) alm <= 2'b11;
    tk(70);
    chk("gen1", 8'(drive.gen1), 8'h00);
    chk("alarm lamp", 8'(drive.alarm_led), 8'h01);
    rd_reg(4'hf);
    chk("unmapped", v, 8'h00);
    $display("warning test done");
  endtask

  task automatic t_auto();
    do_reset();
    wr_reg(ADDR_CFG, 8'h21);
    tk(8);
    rd_reg(ADDR_STAT);
    chk("idle", 8'(v[2:0]), 8'h00);
    @(posedge clk) alm <= 2'b01;
    tk(5);
    @(posedge clk) alm <= 2'b00;
    fire_chk("gen1", 1'b0, 57);
    $display("auto test done");
  endtask

  task automatic t_stag(logic [7:0] c, logic [1:0] a, int n2);
    do_reset();
    wr_reg(ADDR_CFG, c);
    @(posedge clk) begin
      alm <= a;
      misfire <= 1'b1;
    end
    fire_chk("gen1", 1'b0, 63);
    chk("act", 8'(drive.act_led), 8'h01);
    fire_chk("gen2", 1'b1, n2);
    rd_reg(ADDR_FAULT);
    chk("dfail", 8'(v[F_DISCH]), 8'h01);
    $display("stagger test done");
  endtask

  task automatic t_manual();
    do_reset();
    wr_reg(ADDR_CFG, 8'h35);
    @(posedge clk) begin
      ignition <= 1'b1;
      alm <= 2'b11;
    end
    tk(70);
    chk("manual gen1", 8'(drive.gen1), 8'h00);
    rd_reg(ADDR_STAT);
    chk("mode", 8'({v[6], v[2:0]}), 8'h08);
    @(posedge clk) ignition <= 1'b0;
    fire_chk("auto gen1", 1'b0, 62);
    $display("manual test done");
  endtask

  task automatic t_short();
    do_reset();
    wr_reg(ADDR_CFG, 8'h27);
    @(posedge clk) alm <= 2'b01;
    tk(70);
    chk("out2", 8'(drive.out2), 8'h01);
    chk("gen1", 8'(drive.gen1), 8'h00);
    $display("shutdown test done");
  endtask

  task automatic t_buttons();
    int ones;
    ones = 0;
    do_reset();
    @(posedge clk) {btn_a, btn_b} <= 2'b11;
    repeat (12) begin
      tk(1);
      ones += drive.sounder;
    end
    chk("beep", 8'(ones > 0 && ones < 12), 8'h01);
    @(posedge clk) btn_b <= 1'b0;
    tk(40);
    chk("abort", 8'(drive.gen1), 8'h00);
    @(posedge clk) btn_b <= 1'b1;
    fire_chk("hold", 1'b0, 22);
    chk("tone", 8'(drive.sounder), 8'h01);
    $display("button test done");
  endtask

  task automatic t_remote();
    do_reset();
    wr_reg(ADDR_CFG, 8'h40);
    @(posedge clk) press <= 1'b1;
    fire_chk("remote gen1", 1'b0, 3);
    fire_chk("remote gen2", 1'b1, 20);
    rd_reg(ADDR_STAT);
    chk("stat", 8'(v[4:0]), 8'h1a);
    $display("remote test done");
  endtask

  task automatic t_faults();
    int fb;
    do_reset();
    @(posedge clk) cause <= 6'h08;
    repeat (3) @(posedge clk);
    cause <= 6'h00;
    tk(10);
    rd_reg(ADDR_FAULT);
    chk("brief break", v, 8'h00);
    for (int i = 0; i < 6; i++) begin
      fb = (i == 5) ? F_LED : i;
      @(posedge clk) cause <= 6'(1 << i);
      tk(10);
      chk("alert", 8'({drive.out1, drive.sounder, drive.fault_led}), 8'h07);
      chk("spare", 8'(spare_sel), 8'(i == 5));
      rd_reg(ADDR_FAULT);
      chk("fault", v, 8'(1 << fb));
      @(posedge clk) cause <= '0;
      tk(3);
      wr_reg(ADDR_FAULT, 8'hff);
      tk(2);
      rd_reg(ADDR_FAULT);
      chk("clear", v, 8'h00);
    end
    $display("fault test done");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    t_warn();
    t_auto();
    t_stag(8'h64, 2'b10, 20);
    t_stag(8'he1, 2'b01, 40);
    t_manual();
    t_short();
    t_buttons();
    t_remote();
    t_faults();
    give_verdict();
  end
endmodule
